// file: shared/mptu_pkg.sv
// Package: register map, field positions, reset values and states
package mptu_pkg;
	// Register word indices; the byte address is four times the index
	localparam logic [7:0] ADDR_CAPT_HIGH = 8'hf0;
	localparam logic [7:0] ADDR_CAPT_LOW = 8'hf1;
	localparam logic [7:0] ADDR_OVF_CMP = 8'hf2;
	localparam logic [7:0] ADDR_IRQ_PEND = 8'hf3;
	localparam logic [7:0] ADDR_CTRL_ZERO = 8'h30;
	localparam logic [7:0] ADDR_CTRL_ONE = 8'h31;
	localparam logic [7:0] ADDR_CTRL_TWO = 8'h32;
	localparam logic [7:0] ADDR_SETUP = 8'h33;
	localparam logic [7:0] ADDR_OUT_REG = 8'h34;
	localparam logic [7:0] ADDR_VECTOR = 8'h35;
	localparam logic [7:0] ADDR_REP = 8'h36;
	localparam logic [7:0] ADDR_PRE_U = 8'h38;
	localparam logic [7:0] ADDR_PRE_V = 8'h39;
	localparam logic [7:0] ADDR_PRE_W = 8'h3a;
	localparam logic [7:0] ADDR_PRE_P = 8'h3b;
	localparam logic [7:0] ADDR_CMP_STAT = 8'h37;
	// Reset values
	localparam logic [7:0] OVF_CMP_RESET = 8'hff;
	localparam logic [7:0] CTRL_ZERO_RESET = 8'h83;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	// Control zero fields
	localparam int B_TACHO_EN = 6;
	localparam int B_PWM_EN = 5;
	localparam int B_TACHO_CLR = 4;
	localparam int B_PWM_CLR = 3;
	localparam int B_COUNT_MODE = 2;
	localparam int B_COMPL_SEL = 0;
	// Control one fields
	localparam int B_EMERG_EN = 6;
	localparam int B_CLR_ON_CAPT = 5;
	localparam int B_CAPT_SRC = 4;
	localparam int B_SW_CAPT = 3;
	localparam int B_ONESHOT = 2;
	// Control two fields
	localparam int B_REP_SW_EN = 6;
	localparam int B_W_SW_EN = 5;
	localparam int B_V_SW_EN = 4;
	localparam int B_U_SW_EN = 3;
	localparam int B_P_SW_EN = 2;
	localparam int B_SW_XFER = 1;
	localparam int B_XFER_MODE = 0;
	// Setup fields, and the output register select bit B_OUT_REG_SEL
	localparam int B_EMERG_LEVEL = 1;
	localparam int B_DIR_SEL = 0;
	localparam int B_OUT_REG_SEL = 7;
	localparam int B_OUT_ENABLE = 6;
	// Pending bit positions; P_EMERG is the emergency bit of the vector register
	localparam int P_PERIOD = 7;
	localparam int P_CAPT = 6;
	localparam int P_OVF = 5;
	localparam int P_XFER = 4;
	localparam int P_ZERO = 3;
	localparam int P_U = 2;
	localparam int P_V = 1;
	localparam int P_W = 0;
	localparam int P_EMERG = 3;
	// Edge sensitivity codes
	localparam logic [1:0] EDGE_NONE = 2'h0;
	localparam logic [1:0] EDGE_FALL = 2'h1;
	localparam logic [1:0] EDGE_RISE = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	// Tacho counter run state
	typedef enum logic [1:0] {
		MPTU_IDLE = 2'b01,
		MPTU_RUN = 2'b10
	} mptu_state_t;
endpackage

// file: verilog/mptu_phase_cmp.sv
// One phase: active compare register, match flag and single PWM output
`timescale 1ns/1ps
module mptu_phase_cmp
	import mptu_pkg::*;
#(
	parameter int W = 11
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic load,
	input wire logic [W-1:0] preload,
	input wire logic [9:0] pwm_cnt,
	input wire logic count_up,
	input wire logic zero_mode,
	input wire logic dir_sel,
	input wire logic tick,
	output logic [W-1:0] active,
	output logic match,
	output logic pwm_out
);
	logic [W-1:0] act_reg;
	logic [W-1:0] act_next;
	logic hit;
	logic [W-1:0] cnt_ext;

	// Active compare value; zero after reset
	always_comb begin
		act_next = act_reg;
		if (load) begin
			act_next = preload;
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			act_reg <= '0;
		end else begin
			act_reg <= act_next;
		end
	end
	assign active = act_reg;

	// Match counts one direction only in zero-centred mode
	// Counter taken to the compare width on purpose
	assign cnt_ext = W'(pwm_cnt);
	assign hit = tick && (cnt_ext == act_reg);
	assign match = hit && (!zero_mode || (count_up == dir_sel));
	// High while counter is below the compare value; zero holds low
	assign pwm_out = (act_reg != '0) && (cnt_ext < act_reg);
endmodule

// file: verilog/mptu_ctrl.sv
// Motor PWM control: tacho counter, preload transfer, outputs, emergency
`timescale 1ns/1ps
module mptu_ctrl
	import mptu_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic tacho_pin,
	input wire logic emerg_pin,
	input wire logic [5:0] deadtime_in,
	input wire logic [7:0] irq_enable,
	output logic [5:0] motor_out,
	output logic [5:0] motor_oe,
	output logic emerg_irq
);
	// Bus, control and status registers
	logic [7:0] ctl0_reg, ctl0_next, ctl1_reg, ctl1_next, ctl2_reg, ctl2_next;
	logic [7:0] setup_reg, setup_next, outr_reg, outr_next;
	logic [7:0] ovfc_reg, ovfc_next, pend_reg, pend_next, rep_reg, rep_next;
	logic [7:0] repc_reg, repc_next;
	logic [15:0] tcnt_reg, tcnt_next, capt_reg, capt_next;
	logic [9:0] pcnt_reg, pcnt_next;
	logic up_reg, up_next, emp_reg, emp_next;
	logic [10:0] pre_u_reg, pre_v_reg, pre_w_reg, pre_next_u;
	logic [10:0] pre_next_v, pre_next_w;
	logic [9:0] pre_p_reg, pre_next_p;
	logic [7:0] wa_reg;
	logic wr_reg, rd_ok;
	logic [31:0] rdata_reg, rdata_next;
	mptu_state_t tst_reg, tst_next;
	logic [1:0] tacho_sync, emerg_sync;
	logic tacho_d;
	logic cap_ev, ovf_ev, xfer_hw, xfer_sw, zero_ev, per_ev, emerg_ack;
	logic [2:0] ph_match, ph_out, ld_ph;
	logic [10:0] act_u, act_v, act_w;
	logic [9:0] act_p;
	logic wr_now;
	logic [7:0] raw_ev;

	// Two-flop synchronisers for the external pins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tacho_sync <= 2'h0;
			emerg_sync <= 2'h0;
			tacho_d <= 1'b0;
		end else begin
			tacho_sync <= {tacho_sync[0], tacho_pin};
			emerg_sync <= {emerg_sync[0], emerg_pin};
			tacho_d <= tacho_sync[1];
		end
	end

	// Capture source: edge of tacho pin or software trigger
	always_comb begin
		logic rise, fall, pin_ev;
		pin_ev = 1'b0;
		rise = tacho_sync[1] && !tacho_d;
		fall = !tacho_sync[1] && tacho_d;
		case (ctl1_reg[1:0])
			EDGE_FALL: pin_ev = fall;
			EDGE_RISE: pin_ev = rise;
			EDGE_BOTH: pin_ev = rise || fall;
			default: pin_ev = 1'b0;
		endcase
		cap_ev = ctl1_reg[B_CAPT_SRC] ? ctl1_reg[B_SW_CAPT] : pin_ev;
	end

	// Overflow when upper byte reaches compare while counting
	assign ovf_ev = ctl0_reg[B_TACHO_EN] && (tcnt_reg[15:8] == ovfc_reg);
	// Emergency acknowledged per level setting
	assign emerg_ack = ctl1_reg[B_EMERG_EN] &&
		(emerg_sync[1] == setup_reg[B_EMERG_LEVEL]);
	assign wr_now = wr_reg;

	// AHB-Lite address phase capture; zero wait states
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wa_reg <= 8'h00;
			wr_reg <= 1'b0;
			rdata_reg <= 32'h0;
		end else begin
			wr_reg <= hsel && hready && htrans[1] && hwrite;
			if (hsel && hready && htrans[1]) begin
				wa_reg <= haddr[9:2];
			end
			rdata_reg <= rdata_next;
		end
	end
	assign rd_ok = hsel && hready && htrans[1] && !hwrite;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rdata_reg;

	// Read mux; registered so data stands in the data phase
	always_comb begin
		logic [7:0] v;
		v = 8'h00;
		case (haddr[9:2])
			ADDR_CAPT_HIGH: v = capt_reg[15:8];
			ADDR_CAPT_LOW: v = capt_reg[7:0];
			ADDR_OVF_CMP: v = ovfc_reg;
			ADDR_IRQ_PEND: v = pend_reg;
			ADDR_CTRL_ZERO: v = {ctl0_reg[7:2], up_reg, ctl0_reg[0]};
			ADDR_CTRL_ONE: v = ctl1_reg;
			ADDR_CTRL_TWO: v = ctl2_reg;
			ADDR_SETUP: v = setup_reg;
			ADDR_OUT_REG: v = outr_reg;
			ADDR_VECTOR: v = {4'h0, emp_reg, 3'h0};
			ADDR_REP: v = rep_reg;
			ADDR_CMP_STAT: v = repc_reg;
			default: v = 8'h00;
		endcase
		rdata_next = rd_ok ? {24'h0, v} : rdata_reg;
	end

	// Repetition reload and transfer events
	assign xfer_hw = !ctl2_reg[B_XFER_MODE] && ctl0_reg[B_PWM_EN] &&
		(repc_reg == 8'h00) && (pcnt_reg == 10'h000);
	assign xfer_sw = ctl2_reg[B_XFER_MODE] && ctl2_reg[B_SW_XFER];
	assign ld_ph[0] = xfer_hw || (xfer_sw && ctl2_reg[B_U_SW_EN]);
	assign ld_ph[1] = xfer_hw || (xfer_sw && ctl2_reg[B_V_SW_EN]);
	assign ld_ph[2] = xfer_hw || (xfer_sw && ctl2_reg[B_W_SW_EN]);
	assign zero_ev = ctl0_reg[B_PWM_EN] && (pcnt_reg == 10'h000);
	assign per_ev = ctl0_reg[B_PWM_EN] && (pcnt_reg == act_p);

	// Phase compare blocks
	mptu_phase_cmp #(.W(11)) u_ph_u (.hclk(hclk), .hresetn(hresetn),
		.load(ld_ph[0]), .preload(pre_u_reg), .pwm_cnt(pcnt_reg),
		.count_up(up_reg), .zero_mode(ctl0_reg[B_COUNT_MODE]),
		.dir_sel(setup_reg[B_DIR_SEL]), .tick(ctl0_reg[B_PWM_EN]),
		.active(act_u), .match(ph_match[0]), .pwm_out(ph_out[0]));
	mptu_phase_cmp #(.W(11)) u_ph_v (.hclk(hclk), .hresetn(hresetn),
		.load(ld_ph[1]), .preload(pre_v_reg), .pwm_cnt(pcnt_reg),
		.count_up(up_reg), .zero_mode(ctl0_reg[B_COUNT_MODE]),
		.dir_sel(setup_reg[B_DIR_SEL]), .tick(ctl0_reg[B_PWM_EN]),
		.active(act_v), .match(ph_match[1]), .pwm_out(ph_out[1]));
	mptu_phase_cmp #(.W(11)) u_ph_w (.hclk(hclk), .hresetn(hresetn),
		.load(ld_ph[2]), .preload(pre_w_reg), .pwm_cnt(pcnt_reg),
		.count_up(up_reg), .zero_mode(ctl0_reg[B_COUNT_MODE]),
		.dir_sel(setup_reg[B_DIR_SEL]), .tick(ctl0_reg[B_PWM_EN]),
		.active(act_w), .match(ph_match[2]), .pwm_out(ph_out[2]));
	// Period compare also starts at zero
	mptu_phase_cmp #(.W(10)) u_ph_p (.hclk(hclk), .hresetn(hresetn),
		.load(xfer_hw || (xfer_sw && ctl2_reg[B_P_SW_EN])),
		.preload(pre_p_reg), .pwm_cnt(pcnt_reg), .count_up(up_reg),
		.zero_mode(1'b0), .dir_sel(1'b0), .tick(1'b0),
		.active(act_p), .match(), .pwm_out());

	// Raw events in pending-bit order
	assign raw_ev = {per_ev, cap_ev, ovf_ev, xfer_hw || xfer_sw, zero_ev,
		ph_match[0], ph_match[1], ph_match[2]};

	// Next state for all control, counter and pending state
	always_comb begin
		logic [7:0] wd;
		wd = hwdata[7:0];
		ctl0_next = ctl0_reg;
		ctl1_next = ctl1_reg;
		ctl2_next = ctl2_reg;
		setup_next = setup_reg;
		outr_next = outr_reg;
		ovfc_next = ovfc_reg;
		rep_next = rep_reg;
		repc_next = repc_reg;
		pre_next_u = pre_u_reg;
		pre_next_v = pre_v_reg;
		pre_next_w = pre_w_reg;
		pre_next_p = pre_p_reg;
		tcnt_next = tcnt_reg;
		capt_next = capt_reg;
		pcnt_next = pcnt_reg;
		up_next = up_reg;
		pend_next = pend_reg;
		emp_next = emp_reg;
		tst_next = tst_reg;
		// Self-clearing strobes last one cycle
		ctl0_next[B_TACHO_CLR] = 1'b0;
		ctl0_next[B_PWM_CLR] = 1'b0;
		ctl1_next[B_SW_CAPT] = 1'b0;
		ctl2_next[B_SW_XFER] = 1'b0;
		// Mask write clears only bits written 0
		if (wr_now && wa_reg == ADDR_IRQ_PEND) begin
			pend_next = pend_reg & wd;
		end
		// Emergency pending clears only while input inactive
		if (wr_now && wa_reg == ADDR_VECTOR && !wd[P_EMERG] && !emerg_ack) begin
			emp_next = 1'b0;
		end
		if (wr_now) begin
			case (wa_reg)
				ADDR_CTRL_ZERO: ctl0_next = {wd[7:2], 1'b0, wd[0]};
				ADDR_CTRL_ONE: ctl1_next = wd;
				ADDR_CTRL_TWO: ctl2_next = wd;
				ADDR_SETUP: setup_next = wd;
				ADDR_OUT_REG: outr_next = wd;
				ADDR_OVF_CMP: ovfc_next = wd;
				ADDR_REP: rep_next = wd;
				ADDR_PRE_U: pre_next_u = hwdata[10:0];
				ADDR_PRE_V: pre_next_v = hwdata[10:0];
				ADDR_PRE_W: pre_next_w = hwdata[10:0];
				ADDR_PRE_P: pre_next_p = hwdata[9:0];
				default: ;
			endcase
		end
		// PWM counter: classical saw or zero-centred triangle
		if (ctl0_reg[B_PWM_EN]) begin
			if (!ctl0_reg[B_COUNT_MODE]) begin
				up_next = 1'b1;
				pcnt_next = (pcnt_reg >= act_p) ? 10'h000 : pcnt_reg + 10'h001;
			end else if (up_reg) begin
				if (pcnt_reg >= act_p) begin
					up_next = 1'b0;
					pcnt_next = pcnt_reg - 10'h001;
				end else begin
					pcnt_next = pcnt_reg + 10'h001;
				end
			end else if (pcnt_reg == 10'h000) begin
				up_next = 1'b1;
				pcnt_next = 10'h001;
			end else begin
				pcnt_next = pcnt_reg - 10'h001;
			end
		end
		if (ctl0_reg[B_PWM_CLR]) begin
			pcnt_next = 10'h000;
		end
		// Repetition counter reload on hardware transfer
		if (xfer_hw) begin
			repc_next = rep_reg;
		end else if (zero_ev && !ctl2_reg[B_XFER_MODE]) begin
			repc_next = repc_reg - 8'h01;
		end
		// Software update of repetition counter, decremented at once
		if (xfer_sw && ctl2_reg[B_REP_SW_EN]) begin
			repc_next = rep_reg - 8'h01;
		end
		// Tacho counter run state
		case (tst_reg)
			MPTU_IDLE: begin
				if (ctl0_reg[B_TACHO_EN]) begin
					tst_next = MPTU_RUN;
				end
			end
			MPTU_RUN: begin
				if (!ctl0_reg[B_TACHO_EN]) begin
					tst_next = MPTU_IDLE;
				end
			end
			default: tst_next = MPTU_IDLE;
		endcase
		if (ctl0_reg[B_TACHO_EN]) begin
			tcnt_next = tcnt_reg + 16'h0001;
		end
		if (cap_ev) begin
			capt_next = tcnt_reg;
			if (ctl1_reg[B_CLR_ON_CAPT]) begin
				tcnt_next = 16'h0000;
			end
			if (ctl1_reg[B_ONESHOT]) begin
				ctl0_next[B_TACHO_EN] = 1'b0;
			end
		end
		if (ovf_ev) begin
			tcnt_next = 16'h0000;
			if (ctl1_reg[B_ONESHOT]) begin
				ctl0_next[B_TACHO_EN] = 1'b0;
			end
		end
		if (ctl0_reg[B_TACHO_CLR]) begin
			tcnt_next = 16'h0000;
		end
		// Hardware sets win over a clear in the same cycle
		pend_next = pend_next | (raw_ev & irq_enable);
		// Emergency: pending set, output enable dropped
		if (emerg_ack) begin
			emp_next = 1'b1;
			setup_next[B_OUT_ENABLE] = 1'b0;
		end
	end

	// State registers; reset values from the package
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctl0_reg <= CTRL_ZERO_RESET;
			ctl1_reg <= ZERO_BYTE;
			ctl2_reg <= ZERO_BYTE;
			setup_reg <= ZERO_BYTE;
			outr_reg <= ZERO_BYTE;
			ovfc_reg <= OVF_CMP_RESET;
			pend_reg <= ZERO_BYTE;
			rep_reg <= ZERO_BYTE;
			repc_reg <= ZERO_BYTE;
			pre_u_reg <= 11'h000;
			pre_v_reg <= 11'h000;
			pre_w_reg <= 11'h000;
			pre_p_reg <= 10'h000;
			tcnt_reg <= 16'h0000;
			capt_reg <= 16'h0000;
			pcnt_reg <= 10'h000;
			up_reg <= 1'b1;
			emp_reg <= 1'b0;
			tst_reg <= MPTU_IDLE;
		end else begin
			ctl0_reg <= ctl0_next;
			ctl1_reg <= ctl1_next;
			ctl2_reg <= ctl2_next;
			setup_reg <= setup_next;
			outr_reg <= outr_next;
			ovfc_reg <= ovfc_next;
			pend_reg <= pend_next;
			rep_reg <= rep_next;
			repc_reg <= repc_next;
			pre_u_reg <= pre_next_u;
			pre_v_reg <= pre_next_v;
			pre_w_reg <= pre_next_w;
			pre_p_reg <= pre_next_p;
			tcnt_reg <= tcnt_next;
			capt_reg <= capt_next;
			pcnt_reg <= pcnt_next;
			up_reg <= up_next;
			emp_reg <= emp_next;
			tst_reg <= tst_next;
		end
	end

	// Output source select pairs ordered UH UL VH VL WH WL
	always_comb begin
		logic [5:0] pw;
		pw = {ph_out[0], ph_out[0], ph_out[1], ph_out[1], ph_out[2], ph_out[2]};
		if (outr_reg[B_OUT_REG_SEL]) begin
			motor_out = outr_reg[5:0];
		end else if (ctl0_reg[B_COMPL_SEL]) begin
			motor_out = deadtime_in;
		end else begin
			motor_out = pw;
		end
	end
	// Outputs float while emergency pending or output enable is off
	assign motor_oe = (setup_reg[B_OUT_ENABLE] && !emp_reg) ? 6'h3f : 6'h00;
	// Emergency pass-through when handling is off
	assign emerg_irq = ctl1_reg[B_EMERG_EN] ? emp_reg : emerg_sync[1];

	// Assertions
	ovf_stops_oneshot_a: assert property (@(posedge hclk) disable iff (!hresetn)
		ovf_ev && ctl1_reg[B_ONESHOT] && !wr_now |=> !ctl0_reg[B_TACHO_EN])
		else $error("one-shot overflow left counter enabled");
	ovf_zeroes_cnt_a: assert property (@(posedge hclk) disable iff (!hresetn)
		ovf_ev && !ctl0_reg[B_TACHO_CLR] |=> tcnt_reg == 16'h0000)
		else $error("overflow did not zero counter");
	capt_latch_a: assert property (@(posedge hclk) disable iff (!hresetn)
		cap_ev |=> capt_reg == $past(tcnt_reg))
		else $error("capture did not latch count");
	tclr_self_a: assert property (@(posedge hclk) disable iff (!hresetn)
		ctl0_reg[B_TACHO_CLR] |=> tcnt_reg == 16'h0000 && !ctl0_reg[B_TACHO_CLR])
		else $error("tacho clear misbehaved");
	pend_no_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_now && wa_reg == ADDR_IRQ_PEND |=>
		(pend_reg & ~$past(pend_reg)) == ($past(raw_ev) & $past(irq_enable)
		& ~$past(pend_reg)))
		else $error("pending bits set by software");
	pend_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(pend_reg & ~$past(pend_reg) & ~$past(irq_enable)) == 8'h00)
		else $error("pending set while disabled");
	emerg_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
		emerg_ack |=> emp_reg && motor_oe == 6'h00)
		else $error("emergency did not float outputs");
	pass_through_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!ctl1_reg[B_EMERG_EN] |-> emerg_irq == $past(emerg_pin, 2))
		else $error("emergency not passed through");
	swx_self_a: assert property (@(posedge hclk) disable iff (!hresetn)
		ctl2_reg[B_SW_XFER] && !(wr_now && wa_reg == ADDR_CTRL_TWO) |=>
		!ctl2_reg[B_SW_XFER])
		else $error("software transfer did not clear");
	outreg_a: assert property (@(posedge hclk) disable iff (!hresetn)
		outr_reg[B_OUT_REG_SEL] |-> motor_out == outr_reg[5:0])
		else $error("direct output not applied");
	cap_c: cover property (@(posedge hclk) disable iff (!hresetn) cap_ev);
	ovf_c: cover property (@(posedge hclk) disable iff (!hresetn) ovf_ev);
	xfer_c: cover property (@(posedge hclk) disable iff (!hresetn) xfer_hw);
	emerg_c: cover property (@(posedge hclk) disable iff (!hresetn) emerg_ack);
endmodule

// file: test/mptu_motor_model.sv
// Far-side model: tachogenerator, emergency source and power stage
`timescale 1ns/1ps
module mptu_motor_model (
	input wire logic hclk,
	input wire logic emerg_req,
	input wire logic tacho_req,
	input wire logic [5:0] motor_out,
	input wire logic [5:0] motor_oe,
	output logic tacho_pin,
	output logic emerg_pin,
	output logic [5:0] stage_in
);
	// Idle levels before the first edge
	initial begin
		tacho_pin = 1'b0;
		emerg_pin = 1'b0;
		stage_in = 6'h00;
	end
	// Emergency and tacho lines follow their requests after the edge
	always @(posedge hclk) begin
		emerg_pin <= emerg_req;
		tacho_pin <= tacho_req;
	end
	// A floating phase shows the inverse of its last level, never a hold
	always @(posedge hclk) begin
		for (int i = 0; i < 6; i++) begin
			stage_in[i] <= motor_oe[i] ? motor_out[i] : ~stage_in[i];
		end
	end
endmodule

// file: test/tb_motor_pwm_tacho_update_control.sv
// Testbench for the motor PWM control block
`timescale 1ns/1ps
module tb_motor_pwm_tacho_update_control;
	import mptu_pkg::*;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata, rd;
	logic hreadyout, hresp, tacho_pin, emerg_pin, emerg_irq;
	logic emerg_req = 1'b0;
	logic tacho_req = 1'b0;
	logic [7:0] rv;
	logic [5:0] deadtime_in = 6'h00;
	logic [7:0] irq_enable = 8'hff;
	logic [5:0] motor_out, motor_oe, stage_in, d;
	int miscompares = 0;
	int n_checks = 0;
	int mdl_pend = 0;
	// 20 MHz bus clock
	always #25 hclk = ~hclk;
	mptu_ctrl i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .tacho_pin(tacho_pin),
		.emerg_pin(emerg_pin), .deadtime_in(deadtime_in),
		.irq_enable(irq_enable), .motor_out(motor_out),
		.motor_oe(motor_oe), .emerg_irq(emerg_irq));
	mptu_motor_model i_far (.hclk(hclk), .emerg_req(emerg_req),
		.tacho_req(tacho_req),
		.motor_out(motor_out), .motor_oe(motor_oe),
		.tacho_pin(tacho_pin), .emerg_pin(emerg_pin),
		.stage_in(stage_in));
	// Verdict and end of run
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// One comparison of a seen value against the expected one
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Wait for hready at a rising edge, bounded so a stuck slave ends the run
	task automatic wait_rdy();
		int n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1 && n < 50) begin
			n++;
			@(posedge hclk);
		end
		if (n >= 50) begin
			miscompares++;
			complete_run();
		end
	endtask
	// Single AHB-Lite word transfer; read data taken at the data-phase edge
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] r);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {22'h0, a, 2'h0};
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		r = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		bus(1'b1, a, {24'h0, v}, rd);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		bus(1'b0, a, 32'h0, rd);
		check(rd, {24'h0, e});
	endtask
	// Pending mask write: zeros clear, ones leave the bit alone
	task automatic wr_pend(input logic [7:0] v);
		wr(ADDR_IRQ_PEND, v);
		mdl_pend = mdl_pend & v;
	endtask
	// Tacho and transfer pending bits; one edge lets a set land first
	task automatic pend_chk();
		@(posedge hclk);
		bus(1'b0, ADDR_IRQ_PEND, 32'h0, rd);
		check(rd & 32'h70, mdl_pend & 32'h70);
	endtask
	// Watchdog well beyond the roughly nine hundred cycles the tests need
	initial begin
		#1000000;
		miscompares++;
		complete_run();
	end
	initial begin
		void'($urandom(32'h873391af));
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rdchk(ADDR_OVF_CMP, OVF_CMP_RESET);
		rdchk(ADDR_IRQ_PEND, ZERO_BYTE);
		rdchk(ADDR_CTRL_ONE, ZERO_BYTE);
		rdchk(8'h40, ZERO_BYTE);
		$display("test reset done");
		// Pin passes straight through; six cycles cover the synchroniser
		emerg_req <= 1'b1;
		repeat (6) @(posedge hclk);
		check(emerg_irq, 1'b1);
		check(motor_oe, 6'h00);
		emerg_req <= 1'b0;
		repeat (6) @(posedge hclk);
		check(emerg_irq, 1'b0);
		$display("test passthrough done");
		wr(ADDR_SETUP, 8'h40);
		d = 6'($urandom);
		wr(ADDR_OUT_REG, {2'h3, d});
		repeat (2) @(posedge hclk);
		check(motor_out, d);
		check(motor_oe, 6'h3f);
		check(stage_in, d);
		$display("test direct output done");
		wr(ADDR_OUT_REG, 8'h40);
		wr(ADDR_CTRL_ZERO, 8'h81);
		deadtime_in <= 6'($urandom);
		repeat (2) @(posedge hclk);
		check(motor_out, deadtime_in);
		wr(ADDR_CTRL_ZERO, 8'h80);
		repeat (2) @(posedge hclk);
		check(motor_out, 6'h00);
		$display("test output source done");
		// Emergency: pending sticks while the pin is still active
		wr(ADDR_SETUP, 8'h42);
		wr(ADDR_CTRL_ONE, 8'h40);
		emerg_req <= 1'b1;
		repeat (6) @(posedge hclk);
		check(motor_oe, 6'h00);
		check(emerg_irq, 1'b1);
		rdchk(ADDR_VECTOR, 8'h08);
		bus(1'b0, ADDR_SETUP, 32'h0, rd);
		check(rd[B_OUT_ENABLE], 1'b0);
		wr(ADDR_VECTOR, 8'h00);
		rdchk(ADDR_VECTOR, 8'h08);
		emerg_req <= 1'b0;
		repeat (6) @(posedge hclk);
		wr(ADDR_VECTOR, 8'h00);
		rdchk(ADDR_VECTOR, 8'h00);
		$display("test emergency done");
		// Software capture, continuous, clear on capture
		wr(ADDR_CTRL_ZERO, 8'hd0);
		repeat (40) @(posedge hclk);
		wr(ADDR_CTRL_ONE, 8'h38);
		mdl_pend = mdl_pend | (1 << P_CAPT);
		pend_chk();
		rdchk(ADDR_CTRL_ONE, 8'h30);
		rdchk(ADDR_CAPT_HIGH, 8'h00);
		bus(1'b0, ADDR_CAPT_LOW, 32'h0, rd);
		check(rd[7:0] != 8'h00, 1'b1);
		$display("test capture done");
		// Continuous overflow at upper byte 1: counter keeps running
		wr(ADDR_CTRL_ONE, 8'h00);
		wr(ADDR_OVF_CMP, 8'h01);
		wr(ADDR_CTRL_ZERO, 8'hd0);
		repeat (300) @(posedge hclk);
		mdl_pend = mdl_pend | (1 << P_OVF);
		pend_chk();
		bus(1'b0, ADDR_CTRL_ZERO, 32'h0, rd);
		check(rd[B_TACHO_EN], 1'b1);
		check(rd[B_TACHO_CLR], 1'b0);
		wr(ADDR_IRQ_PEND, 8'hff);
		pend_chk();
		wr_pend(8'hdf);
		pend_chk();
		wr_pend(8'hbf);
		pend_chk();
		$display("test continuous overflow done");
		// One-shot overflow with its pending enable off
		irq_enable <= 8'hdf;
		wr(ADDR_CTRL_ONE, 8'h04);
		wr(ADDR_CTRL_ZERO, 8'hd0);
		repeat (300) @(posedge hclk);
		pend_chk();
		bus(1'b0, ADDR_CTRL_ZERO, 32'h0, rd);
		check(rd[B_TACHO_EN], 1'b0);
		$display("test oneshot overflow done");
		// Pin capture in one-shot on a rising edge stops the count
		irq_enable <= 8'hff;
		wr(ADDR_CTRL_ONE, 8'h06);
		wr(ADDR_CTRL_ZERO, 8'hd0);
		repeat (20) @(posedge hclk);
		tacho_req <= 1'b1;
		repeat (10) @(posedge hclk);
		mdl_pend = mdl_pend | (1 << P_CAPT);
		pend_chk();
		bus(1'b0, ADDR_CTRL_ZERO, 32'h0, rd);
		check(rd[B_TACHO_EN], 1'b0);
		bus(1'b0, ADDR_CAPT_LOW, 32'h0, rd);
		check(rd[7:0] > 8'h10 && rd[7:0] < 8'h1c, 1'b1);
		// Edge field: none ignores a fall, falling ignores a rise
		wr_pend(8'hbf);
		wr(ADDR_CTRL_ONE, 8'h00);
		tacho_req <= 1'b0;
		repeat (10) @(posedge hclk);
		pend_chk();
		wr(ADDR_CTRL_ONE, 8'h01);
		tacho_req <= 1'b1;
		repeat (10) @(posedge hclk);
		pend_chk();
		tacho_req <= 1'b0;
		repeat (10) @(posedge hclk);
		mdl_pend = mdl_pend | (1 << P_CAPT);
		pend_chk();
		$display("test pin capture done");
		// Hardware transfer at counter zero, then software transfer
		wr(ADDR_PRE_P, 8'h08);
		wr(ADDR_CTRL_ZERO, 8'ha0);
		repeat (30) @(posedge hclk);
		mdl_pend = mdl_pend | (1 << P_XFER);
		pend_chk();
		wr(ADDR_CTRL_ZERO, 8'h88);
		wr_pend(8'hef);
		pend_chk();
		rv = 8'($urandom);
		wr(ADDR_REP, rv);
		wr(ADDR_PRE_U, 8'h05);
		wr(ADDR_PRE_V, 8'h07);
		wr(ADDR_CTRL_TWO, 8'h4b);
		mdl_pend = mdl_pend | (1 << P_XFER);
		pend_chk();
		rdchk(ADDR_CMP_STAT, rv - 8'h01);
		rdchk(ADDR_CTRL_TWO, 8'h49);
		check(motor_out, 6'h30);
		$display("test preload transfer done");
		complete_run();
	end
endmodule
